// File: seq_engine_regs.svh
/*
  Register offsets, field positions, reset values and frame constants for the
  frame sequence number engine.
  Assumes a plain byte-addressed register port with 8-bit addresses, 32-bit registers 4 apart.
*/
`ifndef SEQ_ENGINE_REGS_SVH
`define SEQ_ENGINE_REGS_SVH

`define SEQ_ADDR_W          8
`define SEQ_REG_CFG         8'h00
`define SEQ_REG_EXTRACT     8'h04
`define SEQ_REG_TX_TRANS    8'h08
`define SEQ_REG_RX_TRANS    8'h0c
`define SEQ_REG_RX_FRM_CNT  8'h10
`define SEQ_REG_TX_FRM_CNT  8'h14
`define SEQ_REG_RX_ERR_CNT  8'h18
`define SEQ_REG_STICKY      8'h1c

`define SEQ_CFG_OFFSET_LSB  0
`define SEQ_CFG_CHKSUM_BIT  16
`define SEQ_CFG_INIT_BIT    17
`define SEQ_CFG_RESP_BIT    18
`define SEQ_CFG_LOOP_BIT    19
`define SEQ_CFG_COPY_BIT    20
`define SEQ_CFG_ERRSEL_LSB  21
`define SEQ_CFG_QUEUE_LSB   24

`define SEQ_EXT_ERR_BIT     0
`define SEQ_EXT_NEXT_BIT    1

`define SEQ_STK_RX_BIT      0
`define SEQ_STK_ERR_BIT     1

`define SEQ_CFG_RESET       32'h0000_0000
`define SEQ_COUNT_RESET     32'h0000_0000

`define SEQ_ETH_MIN_OFFSET  16'h0002
`define SEQ_UDP_MIN_OFFSET  16'h0008
`define SEQ_ERRSEL_SEQ_BIT  0

`endif

// File: seq_engine_pkg.sv
/*
  Types shared by the frame sequence number engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package seq_engine_pkg;
  // Role decoded from the configuration bits.
  typedef enum logic [1:0] {
    role_off,
    role_initiator,
    role_responder
  } role_t;

  typedef logic [15:0] offset_t;
endpackage : seq_engine_pkg

// File: frame_sequence_number_engine.sv
/*
  Frame sequence number engine: one endpoint that stamps and checks sequence
  numbers in test frames seen by the transmit and receive pipeline lookups.
  Assumes the pipeline presents one lookup per cycle as a one-cycle strobe
  with the frame's sequence field already extracted at the offset given on
  seq_offset, and that it applies the returned field one cycle later.
*/
// Behaviour
// - Dual-ended sessions configure both ends as initiators; traffic either way.
// - Sequence field sits at a configured 16-bit byte offset in the PDU.
// - Field: 32-bit number, error flag, 15 zero bits, 16-bit compensation.
// - Modifying a UDP frame adjusts compensation so the checksum holds.
// - No level or version check; valid means test type and MAC pass.
// - Transmit test frame to an initiator endpoint is stamped wherever injected.
// - Test frames at a disabled endpoint pass as ordinary data.
// - Offset and checksum-update flag are configurable, shared by both roles.
// - Initiator role is active when its role bit is written to 1.
// - Responder role is active when its role bit is written to 1.
// - Initiator stamps transmit value into the frame, then adds one.
// - Initiator response receipt sets receive sticky and counts the frame.
// - Initiator checks stored value plus one, counts errors, stores value.
// - Initiator counts only error kinds chosen by the count select field.
// - Errored, next-once, or all received frames may go to a CPU queue.
// - Responder sets sticky, counts, checks; mismatch sets error flag.
// - Responder mismatch counts out-of-order, sets sticky, may extract.
// - Responder loop enable turns messages around; may copy all to CPU.
// - Responder counts transmitted responses and leaves them unmodified.
// - Initiator and responder roles never act at the same time.
// - Message or response is chosen by role and direction only.
`timescale 1ns/1ps
`include "seq_engine_regs.svh"

module frame_sequence_number_engine #(
  parameter int CNT_W   = 32,
  parameter int QUEUE_W = 3
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_b,
  input  wire logic [`SEQ_ADDR_W-1:0]         reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [31:0]                    reg_rdata,
  input  wire logic                           tx_lookup,
  input  wire logic                           rx_lookup,
  input  wire logic                           frame_is_test,
  input  wire logic                           dmac_ok,
  input  wire logic                           frame_is_udp,
  input  wire logic [63:0]                    field_in,
  output logic                                field_valid,
  output logic      [63:0]                    field_out,
  output logic                                as_data,
  output logic                                loop_out,
  output logic                                cpu_extract,
  output logic      [QUEUE_W-1:0]             cpu_queue,
  output seq_engine_pkg::offset_t             seq_offset
);
  import seq_engine_pkg::*;

  // Counters wider than the read port or queues wider than the field fail.
  if (CNT_W < 1 || CNT_W > 32 || QUEUE_W < 1 || QUEUE_W > 8) begin
    $error("frame_sequence_number_engine: unsupported parameters");
  end

  logic [31:0]        cfg;
  logic               extract_on_sequence_error;
  logic               extract_next_rx_frame;
  logic [31:0]        tx_transaction_value;
  logic [31:0]        rx_last_transaction_value;
  logic [CNT_W-1:0]   rx_frame_counter;
  logic [CNT_W-1:0]   tx_frame_counter;
  logic [CNT_W-1:0]   rx_sequence_error_counter;
  logic               sequence_rx_sticky;
  logic               sequence_error_sticky;

  logic               checksum_update_enable;
  logic               initiator_role_enable;
  logic               responder_role_enable;
  logic               loop_message_enable;
  logic               copy_all_to_cpu_enable;
  logic [2:0]         rx_error_count_select;
  role_t              role;
  logic               valid_frame;
  logic               init_tx_msg;
  logic               init_rx_rsp;
  logic               resp_rx_msg;
  logic               resp_tx_rsp;
  logic               any_rx;
  logic               seq_mismatch;
  logic               count_err;
  logic [31:0]        rx_seq;
  logic [31:0]        next_field_seq;
  logic               next_field_err;
  logic [15:0]        next_comp;
  logic               wr_cfg;
  logic               wr_ext;
  logic               wr_stk;
  logic               wr_txt;
  logic               wr_rxt;

  // Configuration fields.
  assign checksum_update_enable = cfg[`SEQ_CFG_CHKSUM_BIT];
  assign initiator_role_enable  = cfg[`SEQ_CFG_INIT_BIT];
  assign responder_role_enable  = cfg[`SEQ_CFG_RESP_BIT];
  assign loop_message_enable    = cfg[`SEQ_CFG_LOOP_BIT];
  assign copy_all_to_cpu_enable = cfg[`SEQ_CFG_COPY_BIT];
  assign rx_error_count_select  = cfg[`SEQ_CFG_ERRSEL_LSB +: 3];

  // Both role bits set is refused as no role, so the endpoint never serves
  // both at once; frames then simply pass as data.
  always_comb begin
    if (initiator_role_enable && !responder_role_enable) begin
      role = role_initiator;
    end else if (responder_role_enable && !initiator_role_enable) begin
      role = role_responder;
    end else begin
      role = role_off;
    end
  end

  // Message versus response follows role and direction only.
  assign valid_frame = frame_is_test && dmac_ok;
  assign init_tx_msg = tx_lookup && valid_frame
                       && role == role_initiator;
  assign init_rx_rsp = rx_lookup && valid_frame && role == role_initiator;
  assign resp_rx_msg = rx_lookup && valid_frame && role == role_responder;
  assign resp_tx_rsp = tx_lookup && valid_frame && role == role_responder;
  assign any_rx      = init_rx_rsp || resp_rx_msg;

  // Sequence check against the last stored value plus one.
  assign rx_seq       = field_in[63:32];
  assign seq_mismatch = rx_seq != rx_last_transaction_value + 32'h1;
  assign count_err    = resp_rx_msg
                        || (init_rx_rsp
                            && rx_error_count_select[`SEQ_ERRSEL_SEQ_BIT]);

  // Register write decode.
  assign wr_cfg = reg_wr && reg_addr == `SEQ_REG_CFG;
  assign wr_ext = reg_wr && reg_addr == `SEQ_REG_EXTRACT;
  assign wr_stk = reg_wr && reg_addr == `SEQ_REG_STICKY;
  assign wr_txt = reg_wr && reg_addr == `SEQ_REG_TX_TRANS;
  assign wr_rxt = reg_wr && reg_addr == `SEQ_REG_RX_TRANS;

  // New field contents; compensation makes the one's complement sum of the
  // 64-bit field unchanged, which keeps the UDP checksum valid without
  // recomputing it over the whole frame.
  always_comb begin
    logic [19:0] old_sum;
    logic [19:0] new_sum;
    logic [15:0] old_fold;
    logic [15:0] new_fold;
    logic [16:0] acc;
    old_sum = 20'h0;
    new_sum = 20'h0;
    old_fold = 16'h0;
    new_fold = 16'h0;
    acc = 17'h0;
    next_field_seq = rx_seq;
    next_field_err = field_in[31];
    if (init_tx_msg) begin
      next_field_seq = tx_transaction_value;
      next_field_err = 1'b0;
    end else if (resp_rx_msg && seq_mismatch) begin
      next_field_err = 1'b1;
    end
    old_sum = {4'h0, field_in[63:48]} + {4'h0, field_in[47:32]}
              + {4'h0, field_in[31:16]} + {4'h0, field_in[15:0]};
    new_sum = {4'h0, next_field_seq[31:16]} + {4'h0, next_field_seq[15:0]}
              + {4'h0, next_field_err, 15'h0};
    old_fold = 16'(({12'h0, old_sum[19:16]} + {1'b0, old_sum[15:0]})
               + {16'h0, ({12'h0, old_sum[19:16]} + {1'b0, old_sum[15:0]})
               > 20'h0ffff});
    new_fold = 16'(({12'h0, new_sum[19:16]} + {1'b0, new_sum[15:0]})
               + {16'h0, ({12'h0, new_sum[19:16]} + {1'b0, new_sum[15:0]})
               > 20'h0ffff});
    acc = {1'b0, old_fold} + {1'b0, ~new_fold};
    next_comp = acc[15:0] + {15'h0, acc[16]};
    if (!(checksum_update_enable && frame_is_udp)) begin
      next_comp = field_in[15:0];
    end
  end

  // Configuration register.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= `SEQ_CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= reg_wdata;
    end
  end

  // Extraction controls; the next-frame request clears itself once used,
  // and a software write in the same cycle loses to that consumption.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      extract_on_sequence_error <= 1'b0;
      extract_next_rx_frame     <= 1'b0;
    end else if (any_rx && extract_next_rx_frame) begin
      extract_next_rx_frame <= 1'b0;
    end else if (wr_ext) begin
      extract_on_sequence_error <= reg_wdata[`SEQ_EXT_ERR_BIT];
      extract_next_rx_frame     <= reg_wdata[`SEQ_EXT_NEXT_BIT];
    end
  end

  // Transmit transaction value: stamp then add one; a stamp beats a write.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_transaction_value <= `SEQ_COUNT_RESET;
    end else if (init_tx_msg) begin
      tx_transaction_value <= tx_transaction_value + 32'h1;
    end else if (wr_txt) begin
      tx_transaction_value <= reg_wdata;
    end
  end

  // Receive side: store the last number seen, in either role.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_last_transaction_value <= `SEQ_COUNT_RESET;
    end else if (any_rx) begin
      rx_last_transaction_value <= rx_seq;
    end else if (wr_rxt) begin
      rx_last_transaction_value <= reg_wdata;
    end
  end

  // Frame and error counters; software writes clear them.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_frame_counter          <= '0;
      tx_frame_counter          <= '0;
      rx_sequence_error_counter <= '0;
    end else begin
      if (any_rx) begin
        rx_frame_counter <= rx_frame_counter + 1'b1;
      end else if (reg_wr && reg_addr == `SEQ_REG_RX_FRM_CNT) begin
        rx_frame_counter <= '0;
      end
      if (resp_tx_rsp) begin
        tx_frame_counter <= tx_frame_counter + 1'b1;
      end else if (reg_wr && reg_addr == `SEQ_REG_TX_FRM_CNT) begin
        tx_frame_counter <= '0;
      end
      if (any_rx && seq_mismatch && count_err) begin
        rx_sequence_error_counter <= rx_sequence_error_counter + 1'b1;
      end else if (reg_wr && reg_addr == `SEQ_REG_RX_ERR_CNT) begin
        rx_sequence_error_counter <= '0;
      end
    end
  end

  // Sticky bits clear by writing one; a new event in the same cycle wins.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sequence_rx_sticky    <= 1'b0;
      sequence_error_sticky <= 1'b0;
    end else begin
      if (any_rx) begin
        sequence_rx_sticky <= 1'b1;
      end else if (wr_stk && reg_wdata[`SEQ_STK_RX_BIT]) begin
        sequence_rx_sticky <= 1'b0;
      end
      if (any_rx && seq_mismatch && count_err) begin
        sequence_error_sticky <= 1'b1;
      end else if (wr_stk && reg_wdata[`SEQ_STK_ERR_BIT]) begin
        sequence_error_sticky <= 1'b0;
      end
    end
  end

  // Per-frame answer to the pipeline, one cycle after the lookup.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      field_valid <= 1'b0;
      field_out   <= 64'h0;
      as_data     <= 1'b0;
      loop_out    <= 1'b0;
      cpu_extract <= 1'b0;
    end else begin
      field_valid <= tx_lookup || rx_lookup;
      as_data     <= (tx_lookup || rx_lookup) && frame_is_test
                     && role == role_off;
      loop_out    <= resp_rx_msg && loop_message_enable;
      cpu_extract <= any_rx && (copy_all_to_cpu_enable
                     || extract_next_rx_frame
                     || (extract_on_sequence_error && seq_mismatch));
      if (init_tx_msg || resp_rx_msg) begin
        field_out <= {next_field_seq, next_field_err, 15'h0, next_comp};
      end else begin
        field_out <= field_in;
      end
    end
  end

  // Queue and offset outputs mirror configuration through flip-flops.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_queue  <= '0;
      seq_offset <= 16'h0;
    end else begin
      cpu_queue  <= cfg[`SEQ_CFG_QUEUE_LSB +: QUEUE_W];
      seq_offset <= cfg[`SEQ_CFG_OFFSET_LSB +: 16];
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `SEQ_REG_CFG:        reg_rdata <= cfg;
        `SEQ_REG_EXTRACT:    reg_rdata <= {30'h0, extract_next_rx_frame,
                                           extract_on_sequence_error};
        `SEQ_REG_TX_TRANS:   reg_rdata <= tx_transaction_value;
        `SEQ_REG_RX_TRANS:   reg_rdata <= rx_last_transaction_value;
        `SEQ_REG_RX_FRM_CNT: reg_rdata <= 32'(rx_frame_counter);
        `SEQ_REG_TX_FRM_CNT: reg_rdata <= 32'(tx_frame_counter);
        `SEQ_REG_RX_ERR_CNT: reg_rdata <= 32'(rx_sequence_error_counter);
        `SEQ_REG_STICKY:     reg_rdata <= {30'h0, sequence_error_sticky,
                                           sequence_rx_sticky};
        default:             reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  stamp_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    init_tx_msg |=> field_out[63:32] == $past(tx_transaction_value)
      && tx_transaction_value == $past(tx_transaction_value) + 32'h1)
    else $error("initiator stamp or increment wrong");
  rx_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    any_rx |=> sequence_rx_sticky
               && rx_frame_counter == $past(rx_frame_counter) + 1'b1)
    else $error("receive count or sticky missing");
  store_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    any_rx |=> rx_last_transaction_value == $past(rx_seq))
    else $error("received number not stored");
  err_select_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (init_rx_rsp && !rx_error_count_select[0])
      |=> $stable(rx_sequence_error_counter))
    else $error("unselected error counted");
  fwd_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (resp_rx_msg && seq_mismatch) |=> field_out[31] && sequence_error_sticky)
    else $error("forward error flag not set");
  tx_unmod_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    resp_tx_rsp |=> field_out == $past(field_in)
                    && tx_frame_counter == $past(tx_frame_counter) + 1'b1)
    else $error("response modified or not counted");
  role_excl_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tx_lookup && !reg_wr && initiator_role_enable && responder_role_enable)
      |=> $stable(tx_transaction_value) && !loop_out)
    else $error("both roles active");
  as_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ((tx_lookup || rx_lookup) && frame_is_test && role == role_off)
      |=> as_data && !cpu_extract && !loop_out)
    else $error("disabled endpoint not passing data");
  next_once_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (any_rx && extract_next_rx_frame)
      |=> cpu_extract && !extract_next_rx_frame)
    else $error("next-frame extraction not single");
  loop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (resp_rx_msg && loop_message_enable) |=> loop_out && field_valid)
    else $error("loopback not issued");
endmodule : frame_sequence_number_engine

// File: frame_pipe_model.sv
/*
  Pipeline and peer model: presents one test frame lookup at a time to the
  sequence engine and captures the answer.
  Assumes the engine answers in the cycle after the lookup is taken.
*/
`timescale 1ns/1ps

module frame_pipe_model (
  input  wire logic        ref_clk,
  output logic             tx_lookup,
  output logic             rx_lookup,
  output logic             frame_is_test,
  output logic             dmac_ok,
  output logic             frame_is_udp,
  output logic [63:0]      field_in,
  input  wire logic        field_valid,
  input  wire logic [63:0] field_out,
  input  wire logic        as_data,
  input  wire logic        loop_out,
  input  wire logic        cpu_extract
);
  // Idle pipeline at time zero.
  initial begin
    tx_lookup     = 1'b0;
    rx_lookup     = 1'b0;
    frame_is_test = 1'b0;
    dmac_ok       = 1'b0;
    frame_is_udp  = 1'b0;
    field_in      = 64'h0;
  end

  // One lookup. The field is inverted once taken, so an engine that samples
  // it late sees a wrong value instead of a lucky stale one.
  task automatic look(
    input  logic        tx,
    input  logic        rx,
    input  logic        test,
    input  logic        mac,
    input  logic        udp,
    input  logic [63:0] f,
    output logic [63:0] fo,
    output logic [3:0]  ans
  );
    @(posedge ref_clk);
    tx_lookup     <= tx;
    rx_lookup     <= rx;
    frame_is_test <= test;
    dmac_ok       <= mac;
    frame_is_udp  <= udp;
    field_in      <= f;
    @(posedge ref_clk);
    tx_lookup <= 1'b0;
    rx_lookup <= 1'b0;
    field_in  <= ~f;
    #1;
    fo  = field_out;
    ans = {field_valid, as_data, loop_out, cpu_extract};
  endtask : look
endmodule : frame_pipe_model

// File: frame_sequence_number_engine_bench.sv
/*
  Self-checking bench for the frame sequence number engine.
  Assumes the pipeline model beside it and the register map header.
*/
`timescale 1ns/1ps
`include "seq_engine_regs.svh"

module frame_sequence_number_engine_bench;
  import seq_engine_pkg::*;
  localparam logic [31:0] B_CHK = 32'h1 << `SEQ_CFG_CHKSUM_BIT;
  localparam logic [31:0] B_INI = 32'h1 << `SEQ_CFG_INIT_BIT;
  localparam logic [31:0] B_RSP = 32'h1 << `SEQ_CFG_RESP_BIT;
  localparam logic [31:0] B_LP  = 32'h1 << `SEQ_CFG_LOOP_BIT;
  localparam logic [31:0] B_CP  = 32'h1 << `SEQ_CFG_COPY_BIT;
  localparam logic [31:0] B_ES  = 32'h1 << `SEQ_CFG_ERRSEL_LSB;
  localparam logic [31:0] B_Q5  = 32'h5 << `SEQ_CFG_QUEUE_LSB;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic tx_lookup, rx_lookup, frame_is_test, dmac_ok, frame_is_udp;
  logic [63:0] field_in, field_out, fo;
  logic field_valid, as_data, loop_out, cpu_extract;
  logic [2:0] cpu_queue;
  offset_t seq_offset;
  logic [3:0] ans;
  int err_total = 0;
  int samples_checked = 0;

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("Error %s expected %h seen %h", n, e, g); end end

  // Clock of 4 ns; inputs change on the rising edge by NBA.
  always #2 ref_clk = ~ref_clk;

  frame_sequence_number_engine u_frame_sequence_number_engine (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_lookup(tx_lookup), .rx_lookup(rx_lookup),
    .frame_is_test(frame_is_test), .dmac_ok(dmac_ok),
    .frame_is_udp(frame_is_udp), .field_in(field_in),
    .field_valid(field_valid), .field_out(field_out), .as_data(as_data),
    .loop_out(loop_out), .cpu_extract(cpu_extract),
    .cpu_queue(cpu_queue), .seq_offset(seq_offset));

  frame_pipe_model u_frame_pipe_model (
    .ref_clk(ref_clk), .tx_lookup(tx_lookup), .rx_lookup(rx_lookup),
    .frame_is_test(frame_is_test), .dmac_ok(dmac_ok),
    .frame_is_udp(frame_is_udp), .field_in(field_in),
    .field_valid(field_valid), .field_out(field_out), .as_data(as_data),
    .loop_out(loop_out), .cpu_extract(cpu_extract));

  // Folded one's complement sum of the four words; both zeros are equal.
  function automatic logic [15:0] ocs(input logic [63:0] f);
    logic [17:0] s;
    s = 18'(f[63:48]) + 18'(f[47:32]) + 18'(f[31:16]) + 18'(f[15:0]);
    s = 18'(s[15:0]) + 18'(s[17:16]);
    s = 18'(s[15:0]) + 18'(s[17:16]);
    return (s[15:0] == 16'hffff) ? 16'h0 : s[15:0];
  endfunction : ocs

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string n);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata)
  endtask : rdchk

  task automatic lk(input logic tx, input logic udp, input logic [63:0] f);
    u_frame_pipe_model.look(tx, !tx, 1'b1, 1'b1, udp, f, fo, ans);
  endtask : lk

  task automatic clr();
    wr(`SEQ_REG_RX_FRM_CNT, 32'h0);
    wr(`SEQ_REG_TX_FRM_CNT, 32'h0);
    wr(`SEQ_REG_RX_ERR_CNT, 32'h0);
    wr(`SEQ_REG_STICKY, 32'h3);
  endtask : clr

  task automatic t_reset();
    rdchk(`SEQ_REG_CFG, `SEQ_CFG_RESET, "cfg");
    rdchk(`SEQ_REG_TX_TRANS, 32'h0, "tx_trans");
    rdchk(`SEQ_REG_RX_TRANS, 32'h0, "rx_trans");
    rdchk(`SEQ_REG_RX_FRM_CNT, `SEQ_COUNT_RESET, "rx_cnt");
    rdchk(`SEQ_REG_RX_ERR_CNT, `SEQ_COUNT_RESET, "err_cnt");
    rdchk(`SEQ_REG_TX_FRM_CNT, `SEQ_COUNT_RESET, "tx_cnt");
    rdchk(`SEQ_REG_STICKY, 32'h0, "sticky");
    rdchk(8'h20, 32'h0, "unmapped");
    `CHK("offset", 16'h0, seq_offset)
  endtask : t_reset

  // Test frames at an endpoint without a role, or with both, are data.
  task automatic t_disabled();
    wr(`SEQ_REG_CFG, 32'h8);
    lk(1'b1, 1'b1, 64'h0000_0000_0000_1111);
    `CHK("as_data", 1'b1, ans[2])
    `CHK("pass", 64'h0000_0000_0000_1111, fo)
    wr(`SEQ_REG_CFG, B_INI | B_RSP | 32'h8);
    lk(1'b1, 1'b1, 64'h0);
    `CHK("both", 1'b1, ans[2])
    rdchk(`SEQ_REG_TX_TRANS, 32'h0, "no_stamp");
  endtask : t_disabled

  task automatic t_init_tx();
    logic [63:0] f;
    f = {32'h0, 1'b0, 15'h0, 16'h1357};
    wr(`SEQ_REG_CFG, B_INI | B_CHK | 32'(`SEQ_UDP_MIN_OFFSET));
    wr(`SEQ_REG_TX_TRANS, 32'h5);
    `CHK("offset", `SEQ_UDP_MIN_OFFSET, seq_offset)
    lk(1'b1, 1'b1, f);
    `CHK("valid", 1'b1, ans[3])
    `CHK("stamp", 32'h5, fo[63:32])
    `CHK("flags", 16'h0, fo[31:16])
    `CHK("comp", ocs(f), ocs(fo))
    lk(1'b1, 1'b1, f);
    `CHK("stamp2", 32'h6, fo[63:32])
    rdchk(`SEQ_REG_TX_TRANS, 32'h7, "tx_next");
    u_frame_pipe_model.look(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, f, fo, ans);
    u_frame_pipe_model.look(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, f, fo, ans);
    rdchk(`SEQ_REG_TX_TRANS, 32'h7, "invalid");
    // The offset of 8 also covers the Ethernet minimum of 2 bytes.
    lk(1'b1, 1'b0, f);
    `CHK("eth", {32'h7, 16'h0, 16'h1357}, fo)
  endtask : t_init_tx

  // The peer also runs as an initiator, so its stamps arrive here.
  task automatic t_init_rx();
    clr();
    wr(`SEQ_REG_CFG, B_INI | B_ES | B_Q5);
    wr(`SEQ_REG_EXTRACT, 32'h1);
    lk(1'b0, 1'b0, {32'h1, 32'h0});
    `CHK("ext1", 1'b0, ans[0])
    lk(1'b0, 1'b0, {32'h3, 32'h0});
    `CHK("ext3", 1'b1, ans[0])
    lk(1'b0, 1'b0, {32'h4, 32'h0});
    `CHK("ext4", 1'b0, ans[0])
    `CHK("queue", 3'h5, cpu_queue)
    rdchk(`SEQ_REG_RX_FRM_CNT, 32'h3, "rx_cnt");
    rdchk(`SEQ_REG_RX_ERR_CNT, 32'h1, "err_cnt");
    rdchk(`SEQ_REG_RX_TRANS, 32'h4, "rx_last");
    rdchk(`SEQ_REG_STICKY, 32'h3, "sticky");
    wr(`SEQ_REG_STICKY, 32'h3);
    wr(`SEQ_REG_CFG, B_INI | B_Q5);
    lk(1'b0, 1'b0, {32'h9, 32'h0});
    rdchk(`SEQ_REG_RX_ERR_CNT, 32'h1, "unselected");
    rdchk(`SEQ_REG_STICKY, 32'h1, "stk_unsel");
    wr(`SEQ_REG_EXTRACT, 32'h2);
    lk(1'b0, 1'b0, {32'ha, 32'h0});
    `CHK("next", 1'b1, ans[0])
    lk(1'b0, 1'b0, {32'hb, 32'h0});
    `CHK("once", 1'b0, ans[0])
    wr(`SEQ_REG_CFG, B_INI | B_CP | B_Q5);
    lk(1'b0, 1'b0, {32'hc, 32'h0});
    `CHK("copy", 1'b1, ans[0])
  endtask : t_init_rx

  task automatic t_resp();
    logic [63:0] f;
    clr();
    wr(`SEQ_REG_RX_TRANS, 32'h0);
    wr(`SEQ_REG_CFG, B_RSP | B_LP | B_CHK | 32'h8);
    wr(`SEQ_REG_EXTRACT, 32'h1);
    f = {32'h1, 16'h0, 16'h2468};
    lk(1'b0, 1'b1, f);
    `CHK("in_order", f, fo)
    `CHK("loop", 4'b1010, ans)
    f = {32'h5, 16'h0, 16'h2468};
    lk(1'b0, 1'b1, f);
    `CHK("fwd_err", {32'h5, 16'h8000}, fo[63:16])
    `CHK("comp", ocs(f), ocs(fo))
    `CHK("extract", 1'b1, ans[0])
    rdchk(`SEQ_REG_RX_FRM_CNT, 32'h2, "rx_cnt");
    rdchk(`SEQ_REG_RX_ERR_CNT, 32'h1, "ooo_cnt");
    rdchk(`SEQ_REG_STICKY, 32'h3, "sticky");
    f = {32'h5, 16'h8000, 16'h1234};
    lk(1'b1, 1'b1, f);
    `CHK("rsp_tx", f, fo)
    `CHK("no_loop", 1'b0, ans[1])
    rdchk(`SEQ_REG_TX_FRM_CNT, 32'h1, "tx_cnt");
    rdchk(`SEQ_REG_TX_TRANS, 32'h8, "tx_kept");
    wr(`SEQ_REG_CFG, B_RSP | 32'h8);
    lk(1'b0, 1'b1, {32'h9, 16'h0, 16'h1234});
    `CHK("no_comp", {32'h9, 16'h8000, 16'h1234}, fo)
  endtask : t_resp

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Reset for 8 cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_disabled();
    t_init_tx();
    t_init_rx();
    t_resp();
    wrap_up();
  end

  // Watchdog: the scenarios need well under 1000 cycles.
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule : frame_sequence_number_engine_bench
